// [scd_decoder.sv]
/*
  Stepper command input decoder: decodes step/direction or
  double-pulse commands, applies the drive-allow input, multiplies
  each input step into microsteps and lowers current when idle.
  Assumes inputs already synchronous to clk_sys; APB slave registers.
*/
`timescale 1ns/1ps
`default_nettype none

module scd_decoder #(
  parameter int IDLE_CYCLES = scd_pkg::IDLE_CYC,
  parameter int GAP_CYCLES  = 2
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  input  wire logic                 step_input,
  input  wire logic                 dirInput,
  input  wire logic                 drive_allow_input,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  output scd_pkg::scd_drive_type    drive
);

  // ****************************************************************
  // Register bus
  // ****************************************************************
  scd_pkg::scd_cfg_type cfg;
  logic [9:0]           resol;
  logic [31:0]          position;
  logic                 idle;
  logic                 enabled;
  logic [15:0]          pending;

  logic setupPhase;
  logic mapped;
  assign setupPhase = psel && !penable;
  assign mapped = (paddr == scd_pkg::ADDR_CONFIG) ||
                  (paddr == scd_pkg::ADDR_RESOL) ||
                  (paddr == scd_pkg::ADDR_STATUS) ||
                  (paddr == scd_pkg::ADDR_POSITION);

  // No wait state: answer in the cycle after setup
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setupPhase;
      pslverr <= setupPhase && !mapped;
      prdata  <= 32'h0000_0000;
      if (setupPhase && !pwrite) begin
        unique case (paddr)
          scd_pkg::ADDR_CONFIG:   prdata <= {26'h0, cfg};
          scd_pkg::ADDR_RESOL:    prdata <= {22'h0, resol};
          scd_pkg::ADDR_STATUS:   prdata <= {13'h0, pending, idle,
                                             enabled, drive.energise};
          scd_pkg::ADDR_POSITION: prdata <= position;
          default:                prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  logic wrStrobe;
  assign wrStrobe = psel && penable && pready && pwrite;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= scd_pkg::CFG_RESET;
    end else if (wrStrobe && paddr == scd_pkg::ADDR_CONFIG) begin
      cfg <= pwdata[scd_pkg::CFG_WIDTH-1:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      resol <= scd_pkg::RES_RESET;
    end else if (wrStrobe && paddr == scd_pkg::ADDR_RESOL) begin
      // Clamp to the supported range
      if (pwdata[9:0] < scd_pkg::RES_MIN) begin
        resol <= scd_pkg::RES_MIN;
      end else if (pwdata[31:10] != 22'h0 ||
                   pwdata[9:0] > scd_pkg::RES_MAX) begin
        resol <= scd_pkg::RES_MAX;
      end else begin
        resol <= pwdata[9:0];
      end
    end
  end

  // ****************************************************************
  // Input decode
  // ****************************************************************
  assign enabled = drive_allow_input ^ cfg.sourcing;

  logic stepPrev;
  logic dirPrev;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stepPrev <= 1'b0;
      dirPrev  <= 1'b0;
    end else begin
      stepPrev <= step_input;
      dirPrev  <= dirInput;
    end
  end

  // Hold off edge decode until the previous samples postdate reset
  logic edgeArmed;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      edgeArmed <= 1'b0;
    end else begin
      edgeArmed <= 1'b1;
    end
  end

  logic stepEdge;
  logic cwPulse;
  logic ccwPulse;
  logic cmdValid;
  logic cmdDir;
  always_comb begin
    stepEdge = cfg.falling ? (stepPrev && !step_input)
                           : (!stepPrev && step_input);
    // A pulse starts on entry into the chosen active level
    cwPulse  = cfg.cwLow ? (stepPrev && !step_input)
                         : (!stepPrev && step_input);
    ccwPulse = cfg.ccwLow ? (dirPrev && !dirInput)
                          : (!dirPrev && dirInput);
    if (cfg.dualPulse) begin
      cmdValid = cwPulse ^ ccwPulse;
      cmdDir   = ccwPulse;
    end else begin
      cmdValid = stepEdge;
      cmdDir   = dirInput;
    end
    cmdValid = cmdValid && enabled && edgeArmed;
  end

  // ****************************************************************
  // Microstep interpolation
  // ****************************************************************
  logic       burstDir;
  logic [7:0] gapCnt;
  logic       emit;
  assign emit = (pending != 16'h0) && (gapCnt == 8'h00);

  // Every accepted edge adds one full burst; a direction reversal drops the rest of the old burst
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pending  <= 16'h0000;
      burstDir <= 1'b0;
    end else if (!enabled) begin
      pending  <= 16'h0000;
    end else begin
      if (cmdValid && (cmdDir == burstDir || pending == 16'h0)) begin
        burstDir <= cmdDir;
        pending  <= pending + {6'h0, resol} - {15'h0, emit};
      end else if (cmdValid) begin
        burstDir <= cmdDir;
        pending  <= {6'h0, resol};
      end else if (emit) begin
        pending  <= pending - 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      gapCnt <= 8'h00;
    end else if (emit) begin
      gapCnt <= 8'(GAP_CYCLES - 1);
    end else if (gapCnt != 8'h00) begin
      gapCnt <= gapCnt - 8'h01;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      position <= 32'h0000_0000;
    end else if (emit && enabled) begin
      position <= burstDir ? position - 32'h0000_0001
                           : position + 32'h0000_0001;
    end
  end

  // ****************************************************************
  // Idle current
  // ****************************************************************
  logic [31:0] idleCnt;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      idleCnt <= 32'h0000_0000;
      idle    <= 1'b0;
    end else if (cmdValid || pending != 16'h0) begin
      idleCnt <= 32'h0000_0000;
      idle    <= 1'b0;
    end else if (idleCnt >= 32'(IDLE_CYCLES - 1)) begin
      idle    <= 1'b1;
    end else begin
      idleCnt <= idleCnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      drive <= '0;
    end else begin
      drive.microStep  <= emit && enabled;
      drive.microDir   <= burstDir;
      drive.energise   <= enabled;
      drive.currentPct <= !enabled ? 8'h00 :
                          (cfg.idleEn && idle) ? scd_pkg::CUR_IDLE
                                               : scd_pkg::CUR_FULL;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_idle_current: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (enabled && cfg.idleEn && idle && !cmdValid) |=>
      drive.currentPct == scd_pkg::CUR_IDLE)
    else $error("idle current not reduced");
  chk_run_current: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (enabled && !(cfg.idleEn && idle)) |=>
      drive.currentPct == scd_pkg::CUR_FULL)
    else $error("running current not full");
  chk_idle_wait: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (cmdValid || pending != 16'h0) |=> !idle)
    else $error("idle flagged while stepping");
  chk_disable_off: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    !enabled |=> !drive.energise && !drive.microStep)
    else $error("windings energised while disabled");
  chk_disable_flush: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    !enabled |=> pending == 16'h0000)
    else $error("steps kept while disabled");
  chk_enable_pol: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (drive_allow_input && !cfg.sourcing) |=> drive.energise)
    else $error("enable polarity wrong");
  chk_source_pol: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (!drive_allow_input && cfg.sourcing) |=> drive.energise)
    else $error("sourcing enable polarity wrong");
  chk_step_edge: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (!cfg.dualPulse && enabled && !cfg.falling && $past(rst_n) &&
     $rose(step_input)) |-> cmdValid)
    else $error("rising edge step missed");
  chk_fall_edge: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (!cfg.dualPulse && enabled && cfg.falling && $past(rst_n) &&
     $fell(step_input)) |-> cmdValid)
    else $error("falling edge step missed");
  chk_wrong_edge: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (!cfg.dualPulse && !cfg.falling && $fell(step_input)) |-> !cmdValid)
    else $error("step taken on inactive edge");
  chk_cw_pulse: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (cfg.dualPulse && enabled && cwPulse && !ccwPulse) |->
      cmdValid && !cmdDir)
    else $error("cw pulse not decoded");
  chk_ccw_pulse: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (cfg.dualPulse && enabled && ccwPulse && !cwPulse) |->
      cmdValid && cmdDir)
    else $error("ccw pulse not decoded");
  chk_pulse_clash: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (cfg.dualPulse && cwPulse && ccwPulse) |-> !cmdValid)
    else $error("clashing pulses accepted");
  chk_dir_level: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (!cfg.dualPulse && cmdValid) |-> ##1 burstDir == $past(dirInput))
    else $error("direction level not applied");
  chk_burst_add: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (enabled && cmdValid && pending == 16'h0) |=>
      pending == {6'h0, $past(resol)})
    else $error("burst length wrong");
  chk_micro_space: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (GAP_CYCLES > 1 && drive.microStep) |=> !drive.microStep)
    else $error("microsteps too close");
  chk_res_range: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    resol >= scd_pkg::RES_MIN && resol <= scd_pkg::RES_MAX)
    else $error("resolution out of range");
  chk_no_loss: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (enabled && cmdValid && pending != 16'h0 && cmdDir == burstDir &&
     $stable(enabled)) |=>
      pending == $past(pending) + {6'h0, $past(resol)} -
                 {15'h0, $past(emit)})
    else $error("step lost");
  chk_reset_defaults: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    $rose(rst_n) |-> cfg == scd_pkg::CFG_RESET &&
      resol == scd_pkg::RES_RESET)
    else $error("defaults not restored by reset");

  // ****************************************************************
  // Cover points
  // ****************************************************************
  cov_step_dir: cover property (@(posedge clk_sys)
    !cfg.dualPulse && cmdValid);
  cov_fall_step: cover property (@(posedge clk_sys)
    !cfg.dualPulse && cfg.falling && cmdValid);
  cov_dual: cover property (@(posedge clk_sys)
    cfg.dualPulse && cmdValid && cmdDir);
  cov_idle: cover property (@(posedge clk_sys)
    drive.currentPct == scd_pkg::CUR_IDLE);
  cov_disable: cover property (@(posedge clk_sys)
    $fell(enabled) && pending != 16'h0);

endmodule : scd_decoder

`default_nettype wire

// [scd_pkg.sv]
/*
  Package for the stepper command input decoder: register offsets,
  field positions, reset values, timing constants and carrier types.
  Assumes a 200 MHz system clock and an APB register bus.
*/
`default_nettype none
package scd_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [11:0] ADDR_CONFIG   = 12'h000;
  localparam logic [11:0] ADDR_RESOL    = 12'h004;
  localparam logic [11:0] ADDR_STATUS   = 12'h008;
  localparam logic [11:0] ADDR_POSITION = 12'h00C;

  // Config field positions
  localparam int CFG_MODE     = 0;
  localparam int CFG_FALLING  = 1;
  localparam int CFG_CWLOW    = 2;
  localparam int CFG_CCWLOW   = 3;
  localparam int CFG_SOURCING = 4;
  localparam int CFG_IDLEEN   = 5;
  localparam int CFG_WIDTH    = 6;

  localparam logic [5:0] CFG_RESET = 6'h20;

  // Resolution: microsteps per input step, 1 .. 512
  localparam int          RES_WIDTH = 10;
  localparam logic [9:0]  RES_RESET = 10'h001;
  localparam logic [9:0]  RES_MAX   = 10'h200;
  localparam logic [9:0]  RES_MIN   = 10'h001;

  // Idle current: 60 percent of run current
  localparam logic [7:0]  CUR_FULL = 8'h64;
  localparam logic [7:0]  CUR_IDLE = 8'h3C;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ       = 200;
  localparam int MAX_STEP_KHZ  = 200;
  // Shortest step period in clock cycles
  localparam int STEP_PERIOD_CYC = (CLK_MHZ * 1000) / MAX_STEP_KHZ;
  // Standstill time before the winding current is reduced to CUR_IDLE
  localparam int IDLE_MS       = 500;
  localparam int IDLE_CYC      = IDLE_MS * CLK_MHZ * 1000;

  typedef struct packed {
    logic       idleEn;
    logic       sourcing;
    logic       ccwLow;
    logic       cwLow;
    logic       falling;
    logic       dualPulse;
  } scd_cfg_type;

  typedef struct packed {
    logic       microStep;
    logic       microDir;
    logic       energise;
    logic [7:0] currentPct;
  } scd_drive_type;

endpackage : scd_pkg
`default_nettype wire

// [scd_ctrl_model.sv]
/*
  Motion controller model: drives the step, direction and drive-allow
  lines. Assumes the bench calls its tasks and supplies clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module scd_ctrl_model #(
  parameter int HOLD_CYC = scd_pkg::STEP_PERIOD_CYC / 2
) (
  input  wire logic clk_sys,
  output var  logic stepLine,
  output var  logic dirLine,
  output var  logic allowLine
);
  // ****************
  // Line drive
  // ****************
  initial begin
    stepLine  = 1'b0;
    dirLine   = 1'b0;
    allowLine = 1'b1;
  end

  // Half of the shortest step period per level; direction held longer
  task automatic setLine(input logic onDir, input logic val);
    @(posedge clk_sys);
    if (onDir) dirLine <= val;
    else stepLine <= val;
    repeat (onDir ? 2 * HOLD_CYC : HOLD_CYC) @(posedge clk_sys);
  endtask : setLine

  task automatic setAllow(input logic val);
    @(posedge clk_sys);
    allowLine <= val;
    repeat (4) @(posedge clk_sys);
  endtask : setAllow
endmodule : scd_ctrl_model
`default_nettype wire

// [stepper_command_input_decoder_bench.sv]
/*
  Bench for the command input decoder: registers, step decoding,
  drive-allow and idle current. Assumes scd_pkg and the model compiled.
*/
`timescale 1ns/1ps
`default_nettype none
module stepper_command_input_decoder_bench;
  // ****************
  // Signals
  // ****************
  logic                   clk_sys = 1'b0;
  logic                   rst_n   = 1'b0;
  logic                   psel    = 1'b0;
  logic                   penable = 1'b0;
  logic                   pwrite  = 1'b0;
  logic [11:0]            paddr   = 12'h000;
  logic [31:0]            pwdata  = 32'h00000000;
  logic [31:0]            prdata;
  logic                   pready;
  logic                   pslverr;
  logic                   stepLine;
  logic                   dirLine;
  logic                   allowLine;
  scd_pkg::scd_drive_type drive;
  int                     errCount    = 0;
  int                     totalChecks = 0;
  int                     msCount     = 0;
  logic                   lastDir;
  logic [7:0]             lastPct;

  always #2.5 clk_sys = ~clk_sys;

  scd_decoder #(.IDLE_CYCLES(50), .GAP_CYCLES(2)) scd_decoder_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .step_input(stepLine),
    .dirInput(dirLine), .drive_allow_input(allowLine), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .drive(drive));

  scd_ctrl_model scd_ctrl_model_inst (.clk_sys(clk_sys),
    .stepLine(stepLine), .dirLine(dirLine), .allowLine(allowLine));

  always @(posedge clk_sys) begin
    if (drive.microStep === 1'b1) begin
      msCount++;
      lastDir = drive.microDir;
      lastPct = drive.currentPct;
    end
  end

  // ****************
  // Helpers
  // ****************
  task automatic check(input logic ok, input string msg);
    totalChecks++;
    if (ok !== 1'b1) begin
      errCount++;
      $display("ERROR at %0t: %s", $time, msg);
    end
  endtask : check

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    check(n < 20, "bus answer missing");
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rdChk(input logic [11:0] a, input logic [31:0] x,
                       input logic xe, input string msg);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h00000000, r, e);
    check(r === x && e === xe, msg);
  endtask : rdChk

  // One line change, then compare the microstep count and direction
  task automatic stepChk(input logic onDir, input logic val,
                         input int x, input logic xd, input string msg);
    msCount = 0;
    scd_ctrl_model_inst.setLine(onDir, val);
    check(msCount == x && (x == 0 || lastDir === xd), msg);
  endtask : stepChk

  task automatic allowChk(input logic al, input logic [31:0] cfg,
                          input logic x);
    wr(scd_pkg::ADDR_CONFIG, cfg);
    scd_ctrl_model_inst.setAllow(al);
    check(drive.energise === x, "energise level");
  endtask : allowChk

  // ****************
  // Scenarios
  // ****************
  task automatic testDefaults;
    rdChk(scd_pkg::ADDR_CONFIG, 32'h00000020, 1'b0, "config reset");
    rdChk(scd_pkg::ADDR_RESOL, 32'h00000001, 1'b0, "resol reset");
    rdChk(12'h010, 32'h00000000, 1'b1, "unmapped read");
    stepChk(1'b0, 1'b1, 1, 1'b0, "rising step");
    stepChk(1'b0, 1'b0, 0, 1'b0, "falling ignored");
    check(drive.currentPct === scd_pkg::CUR_IDLE, "idle current");
    rdChk(scd_pkg::ADDR_STATUS, 32'h00000007, 1'b0, "status idle");
  endtask : testDefaults

  task automatic testResol;
    wr(scd_pkg::ADDR_RESOL, 32'h000003FF);
    rdChk(scd_pkg::ADDR_RESOL, 32'h00000200, 1'b0, "resol max");
    wr(scd_pkg::ADDR_RESOL, 32'h00000000);
    rdChk(scd_pkg::ADDR_RESOL, 32'h00000001, 1'b0, "resol min");
    wr(scd_pkg::ADDR_RESOL, 32'h00000004);
    stepChk(1'b1, 1'b1, 0, 1'b1, "dir alone");
    stepChk(1'b0, 1'b1, 4, 1'b1, "burst ccw");
    check(lastPct === scd_pkg::CUR_FULL, "run current");
    stepChk(1'b0, 1'b0, 0, 1'b1, "fall idle");
    stepChk(1'b0, 1'b1, 4, 1'b1, "max rate step");
    wr(scd_pkg::ADDR_CONFIG, 32'h00000000);
    stepChk(1'b0, 1'b0, 0, 1'b1, "fall no idle");
    check(drive.currentPct === scd_pkg::CUR_FULL, "idle off");
    rdChk(scd_pkg::ADDR_POSITION, 32'hFFFFFFF9, 1'b0, "position");
  endtask : testResol

  task automatic testModes;
    wr(scd_pkg::ADDR_CONFIG, 32'h00000022);
    stepChk(1'b1, 1'b0, 0, 1'b0, "dir low");
    stepChk(1'b0, 1'b1, 0, 1'b0, "rise ignored");
    stepChk(1'b0, 1'b0, 4, 1'b0, "falling step cw");
    wr(scd_pkg::ADDR_CONFIG, 32'h00000021);
    stepChk(1'b0, 1'b1, 4, 1'b0, "cw high");
    stepChk(1'b0, 1'b0, 0, 1'b0, "cw release");
    stepChk(1'b1, 1'b1, 4, 1'b1, "ccw high");
    stepChk(1'b1, 1'b0, 0, 1'b1, "ccw release");
    wr(scd_pkg::ADDR_CONFIG, 32'h0000002D);
    stepChk(1'b0, 1'b1, 0, 1'b0, "cw low release");
    stepChk(1'b0, 1'b0, 4, 1'b0, "cw low");
    stepChk(1'b1, 1'b1, 0, 1'b1, "ccw low release");
    stepChk(1'b1, 1'b0, 4, 1'b1, "ccw low");
  endtask : testModes

  task automatic testAllow;
    allowChk(1'b0, 32'h00000020, 1'b0);
    stepChk(1'b0, 1'b1, 0, 1'b0, "disabled step");
    stepChk(1'b0, 1'b0, 0, 1'b0, "disabled fall");
    rdChk(scd_pkg::ADDR_STATUS, 32'h00000004, 1'b0, "status off");
    allowChk(1'b0, 32'h00000030, 1'b1);
    allowChk(1'b1, 32'h00000030, 1'b0);
    allowChk(1'b1, 32'h00000020, 1'b1);
  endtask : testAllow

  // Reset in mid-run must bring back the default command decoding
  task automatic testReset;
    wr(scd_pkg::ADDR_CONFIG, 32'h0000002D);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    rdChk(scd_pkg::ADDR_CONFIG, 32'h00000020, 1'b0, "config default");
    rdChk(scd_pkg::ADDR_POSITION, 32'h00000000, 1'b0, "position clear");
    stepChk(1'b0, 1'b1, 1, 1'b0, "step after reset");
  endtask : testReset

  // ****************
  // Run control
  // ****************
  task automatic finishTest;
    $display("Checks %0d, errors %0d", totalChecks, errCount);
    if (errCount == 0 && totalChecks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finishTest

  initial begin
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    testDefaults();
    testResol();
    testModes();
    testAllow();
    testReset();
    finishTest();
  end

  initial begin
    repeat (60000) @(posedge clk_sys);
    errCount++;
    $display("ERROR at %0t: watchdog expired", $time);
    finishTest();
  end
endmodule : stepper_command_input_decoder_bench
`default_nettype wire
